// ==== rtl/rgbp_pkg.sv ====
package rgbp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_COLOUR_FIRST    = 8'h00;
  localparam logic [7:0] REG_COLOUR_LAST     = 8'h0B;
  localparam logic [7:0] REG_AUDIO_LED_LEVEL = 8'h0C;
  localparam logic [7:0] REG_AUDIO_SYNC_CTRL = 8'h0D;
  localparam logic [7:0] REG_AUDIO_THRESHOLD = 8'h0E;
  localparam logic [7:0] REG_ENABLES         = 8'h11;
  localparam logic [7:0] REG_FREQ_SEL        = 8'h10;
  localparam logic [7:0] REG_STATUS          = 8'h14;
  localparam logic [7:0] REG_RESET_VAL       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CUR_HI       = 7;
  localparam int CUR_LO       = 6;
  localparam int DUTY_HI      = 5;
  localparam int GAIN_HI      = 7;
  localparam int GAIN_LO      = 5;
  localparam int HPF_BIT      = 4;
  localparam int AGC_BIT      = 3;
  localparam int SYNC_BIT     = 2;
  localparam int SPEED_HI     = 1;
  localparam int THR_HI       = 3;
  localparam int ACTIVE_BIT   = 7;
  localparam int BOOST_BIT    = 6;
  localparam int FREQ_HI_BIT  = 4;
  localparam int FREQ_LO_BIT  = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int  CLK_HZ        = 40_000_000;
  localparam int  PWM_SLOTS     = 63;
  localparam logic [5:0] SLOT_LAST = 6'h3E;
  localparam int  PWM_HZ_SLOW   = 9920;
  // Slot length at the slowest rate; faster codes divide it by 2 or 4
  localparam int  SLOT_CYCLES   = CLK_HZ / (PWM_HZ_SLOW * PWM_SLOTS);
  localparam int  SOFTSTART_MS  = 10;
  localparam int  SOFTSTART_CYC = CLK_HZ / 1000 * SOFTSTART_MS;
  localparam int  REFRESH_HZ_HI = 15;
  localparam int  REFRESH_CYC   = CLK_HZ / REFRESH_HZ_HI;
  localparam int  FAST_CYC      = 4096;
  localparam int  SET_STAGGER   = 16;
  localparam int  SETS          = 4;
  localparam int  OUTS          = 12;

  // High-pass shift per corner setting
  localparam int  HPF_SHIFT_LO  = 8;
  localparam int  HPF_SHIFT_HI  = 5;

  typedef enum logic [2:0] {
    RGBP_STANDBY = 3'b001,
    RGBP_SOFT    = 3'b010,
    RGBP_NORMAL  = 3'b100
  } rgbp_mode_type;
endpackage

// ==== rtl/rgbp_core.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
// Behaviour
// - Twelve outputs, each with 6-bit duty; on-fraction is duty/63.
// - Bits 7:6 select quarter, half, three-quarter or full current.
// - A colour set is active only while its own enable bit is one.
// - All colour outputs stay off while device-active is zero.
// - PWM rate select: 00 slowest, 01 double, 10 and 11 fourfold.
// - Red starts at slot 0, green centred, blue ends at last slot.
// - Each set's period start is offset from the other sets.
// - Left and right audio are summed into one signal path.
// - Audio LED brightness follows the peak detector after gain.
// - Audio control bits 7:5 select attenuation, 0 dB to -42 dB.
// - Audio control bit 4 picks the high-pass corner, 80 or 510 Hz.
// - Bit 3 enables automatic gain; else the manual gain applies.
// - Bit 2 enables audio synchronisation of the audio LED.
// - While synchronised, the host-written level byte is ignored.
// - Bits 1:0 select audio LED refresh: fastest, 15, 7.5, 3.75 Hz.
// - Threshold bits 3:0 set minimum level; zero disables it.
// - Audio LED driver enabled when synchronised or level nonzero.
// - Audio LED current is level/255 of full scale, linear.
// - Device-active low means standby; registers stay writable.
// - During boost soft-start all LED outputs are forced off.
// - Colour bytes at 00h-0Bh in R,G,B order per set; level at 0Ch.
module rgbp_core
  import rgbp_pkg::*;
#(
  parameter int SOFTSTART_CYCLES = SOFTSTART_CYC,
  parameter int REFRESH_CYCLES   = REFRESH_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Audio samples from the converter, signed
  input  wire logic [11:0] audio_left,
  input  wire logic [11:0] audio_right,
  // Colour sinks: on level and current select
  output logic      [11:0] colour_on,
  output logic      [23:0] colour_cur_sel,
  // Audio LED
  output logic             audio_led_enable,
  output logic      [7:0]  audio_led_current
);
  import rgbp_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]     colour_ctl [OUTS];
  logic [7:0]     audio_led_level;
  logic [7:0]     audio_sync_control;
  logic [7:0]     audio_threshold;
  logic [7:0]     enables;
  logic [7:0]     freq_sel;
  rgbp_mode_type  mode;
  logic [7:0]     rd_mux;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < OUTS; i++) colour_ctl[i] <= REG_RESET_VAL;
      audio_led_level    <= REG_RESET_VAL;
      audio_sync_control <= REG_RESET_VAL;
      audio_threshold    <= REG_RESET_VAL;
      enables            <= REG_RESET_VAL;
      freq_sel           <= REG_RESET_VAL;
    end else if (wr) begin
      // Writes accepted in every mode
      if (addr <= REG_COLOUR_LAST) begin
        colour_ctl[addr[3:0]] <= wdata;
      end
      unique case (addr)
        REG_AUDIO_LED_LEVEL: audio_led_level    <= wdata;
        REG_AUDIO_SYNC_CTRL: audio_sync_control <= wdata;
        REG_AUDIO_THRESHOLD: audio_threshold    <= wdata;
        REG_FREQ_SEL:        freq_sel           <= wdata;
        REG_ENABLES:         enables            <= wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (addr <= REG_COLOUR_LAST) rd_mux = colour_ctl[addr[3:0]];
    unique case (addr)
      REG_AUDIO_LED_LEVEL: rd_mux = audio_led_level;
      REG_AUDIO_SYNC_CTRL: rd_mux = audio_sync_control;
      REG_AUDIO_THRESHOLD: rd_mux = audio_threshold;
      REG_FREQ_SEL:        rd_mux = freq_sel;
      REG_ENABLES:         rd_mux = enables;
      REG_STATUS:          rd_mux = {5'h00, mode};
      default: ;
    endcase
  end

  // Idle read data is zero so a stale byte never looks valid
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rdata <= 8'h00;
    else if (rd) rdata <= rd_mux;
    else rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Mode: standby, boost soft-start, normal
  // ----------------------------------------------------------------
  logic [23:0] soft_cnt;
  logic        boost_prev;
  wire  active_bit = enables[ACTIVE_BIT];
  wire  boost_bit  = enables[BOOST_BIT];

  // Remember the boost bit so a later rising write restarts soft-start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) boost_prev <= 1'b0;
    else boost_prev <= boost_bit;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode     <= RGBP_STANDBY;
      soft_cnt <= 24'h000000;
    end else begin
      unique case (mode)
        RGBP_STANDBY: if (active_bit) begin
          mode     <= boost_bit ? RGBP_SOFT : RGBP_NORMAL;
          soft_cnt <= 24'h000000;
        end
        RGBP_SOFT: begin
          soft_cnt <= soft_cnt + 24'h000001;
          if (!active_bit) mode <= RGBP_STANDBY;
          else if (soft_cnt == 24'(SOFTSTART_CYCLES - 1)) mode <= RGBP_NORMAL;
        end
        RGBP_NORMAL: begin
          soft_cnt <= 24'h000000;
          if (!active_bit) mode <= RGBP_STANDBY;
          else if (boost_bit && !boost_prev) mode <= RGBP_SOFT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PWM slot timing
  // ----------------------------------------------------------------
  logic [11:0] div_cnt;
  logic [11:0] div_top;
  logic [7:0]  slot;     // runs 0 to 62; sets are staggered by a per-set offset
  logic [1:0]  rate;

  assign rate = {freq_sel[FREQ_HI_BIT], freq_sel[FREQ_LO_BIT]};

  always_comb begin
    unique case (rate)
      2'b00:   div_top = 12'(SLOT_CYCLES - 1);
      2'b01:   div_top = 12'(SLOT_CYCLES / 2 - 1);
      default: div_top = 12'(SLOT_CYCLES / 4 - 1);
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 12'h000;
      slot    <= 8'h00;
    end else if (div_cnt >= div_top) begin
      div_cnt <= 12'h000;
      slot    <= (slot[5:0] == SLOT_LAST) ? 8'h00 : slot + 8'h01;
    end else begin
      div_cnt <= div_cnt + 12'h001;
    end
  end

  wire slot_tick = (div_cnt >= div_top);

  // ----------------------------------------------------------------
  // Per-output pulse placement
  // ----------------------------------------------------------------
  logic [7:0] latched [OUTS];
  wire  run = (mode == RGBP_NORMAL) && active_bit;

  genvar g;
  generate
    for (g = 0; g < OUTS; g++) begin : g_out
      localparam int SET   = g / 3;
      localparam int COLOR = g % 3;
      logic [5:0] local_slot;
      logic [5:0] duty;
      logic [6:0] lo;
      logic [6:0] hi;
      logic       on;
      // Offset of each set's period start
      assign local_slot = 6'((32'(slot[5:0]) + PWM_SLOTS
                          - SET * SET_STAGGER) % PWM_SLOTS);
      assign duty = latched[g][DUTY_HI:0];
      always_comb begin
        unique case (COLOR)
          0: begin lo = 7'h00; hi = {1'b0, duty}; end
          1: begin
            lo = 7'((PWM_SLOTS - 32'(duty)) / 2);
            hi = 7'((PWM_SLOTS - 32'(duty)) / 2 + 32'(duty));
          end
          default: begin
            lo = 7'(PWM_SLOTS - 32'(duty));
            hi = 7'(PWM_SLOTS);
          end
        endcase
      end
      assign on = ({1'b0, local_slot} >= lo) && ({1'b0, local_slot} < hi);
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          latched[g]            <= REG_RESET_VAL;
          colour_on[g]          <= 1'b0;
          colour_cur_sel[2*g+:2] <= 2'b00;
        end else begin
          if (slot_tick && local_slot == SLOT_LAST) latched[g] <= colour_ctl[g];
          colour_on[g] <= run && enables[SET] && on;
          colour_cur_sel[2*g+:2] <= latched[g][CUR_HI:CUR_LO];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Audio path
  // ----------------------------------------------------------------
  logic signed [12:0] mixed;
  logic signed [19:0] hp_state;
  logic signed [13:0] hp_out;
  logic        [12:0] magnitude;
  logic        [12:0] gained;
  logic        [12:0] peak;
  logic        [2:0]  agc_gain;
  logic        [2:0]  gain_use;
  logic        [12:0] thr_level;
  logic        [7:0]  audio_val;
  logic        [24:0] refresh_cnt;
  logic        [24:0] refresh_top;
  wire  sync_on = audio_sync_control[SYNC_BIT];

  assign mixed = $signed({audio_left[11], audio_left})
               + $signed({audio_right[11], audio_right});
  assign hp_out = 14'(mixed - 13'(hp_state >>> 7));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) hp_state <= 20'h00000;
    else if (audio_sync_control[HPF_BIT])
      hp_state <= hp_state + 20'(hp_out >>> HPF_SHIFT_HI);
    else
      hp_state <= hp_state + 20'(hp_out >>> HPF_SHIFT_LO);
  end

  assign magnitude = hp_out[13] ? 13'(-hp_out) : 13'(hp_out);
  assign gain_use  = audio_sync_control[AGC_BIT] ? agc_gain
                   : audio_sync_control[GAIN_HI:GAIN_LO];
  assign gained    = magnitude >> gain_use;
  // Threshold steps of 16 counts; code zero leaves the gate open
  assign thr_level = 13'({audio_threshold[THR_HI:0], 4'h0});

  always_comb begin
    unique case (audio_sync_control[SPEED_HI:0])
      2'b00:   refresh_top = 25'(FAST_CYC - 1);
      2'b01:   refresh_top = 25'(REFRESH_CYCLES - 1);
      2'b10:   refresh_top = 25'(REFRESH_CYCLES * 2 - 1);
      default: refresh_top = 25'(REFRESH_CYCLES * 4 - 1);
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      peak        <= 13'h0000;
      refresh_cnt <= 25'h0000000;
      agc_gain    <= 3'h0;
      audio_val   <= 8'h00;
    end else if (refresh_cnt >= refresh_top) begin
      refresh_cnt <= 25'h0000000;
      peak        <= 13'h0000;
      audio_val   <= (peak <= thr_level) ? 8'h00 : peak[11:4];
      // Automatic gain: back off on clipping, boost when quiet
      if (peak[12] && agc_gain != 3'h7) agc_gain <= agc_gain + 3'h1;
      else if (!peak[11] && agc_gain != 3'h0) agc_gain <= agc_gain - 3'h1;
    end else begin
      refresh_cnt <= refresh_cnt + 25'h0000001;
      if (gained > peak) peak <= gained;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      audio_led_enable  <= 1'b0;
      audio_led_current <= 8'h00;
    end else begin
      audio_led_enable  <= run && (sync_on || audio_led_level != 8'h00);
      if (!run) audio_led_current <= 8'h00;
      else audio_led_current <= sync_on ? audio_val : audio_led_level;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_standby_dark: assert property (@(posedge clock) disable iff (!nrst)
    !active_bit |=> ##1 colour_on == 12'h000) else $error("colour on in standby");
  a_set_gate: assert property (@(posedge clock) disable iff (!nrst)
    enables[3:0] == 4'h0 && $stable(enables) |=> colour_on == 12'h000)
    else $error("disabled set on");
  a_soft_dark: assert property (@(posedge clock) disable iff (!nrst)
    mode == RGBP_SOFT |=> audio_led_current == 8'h00) else $error("led in soft start");
  a_audio_led_enable: assert property (@(posedge clock) disable iff (!nrst)
    run && audio_led_level != 8'h00 |=> audio_led_enable) else $error("audio_led not enabled");
  a_audio_led_manual: assert property (@(posedge clock) disable iff (!nrst)
    run && !sync_on |=> audio_led_current == $past(audio_led_level))
    else $error("manual level wrong");
  a_slot_range: assert property (@(posedge clock) disable iff (!nrst)
    slot[5:0] <= SLOT_LAST) else $error("slot out of range");
  a_read_data: assert property (@(posedge clock) disable iff (!nrst)
    rd && addr == REG_AUDIO_LED_LEVEL && !wr |=> rdata == $past(audio_led_level))
    else $error("read data wrong");
  a_read_idle: assert property (@(posedge clock) disable iff (!nrst)
    !rd |=> rdata == 8'h00) else $error("rdata not idle");
  a_boost_restart: assert property (@(posedge clock) disable iff (!nrst)
    mode == RGBP_NORMAL && active_bit && boost_bit && !boost_prev
    |=> mode == RGBP_SOFT) else $error("boost restart missed");
  a_cur_follow: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> colour_cur_sel[1:0] == $past(latched[0][CUR_HI:CUR_LO]))
    else $error("current select wrong");
  // Watching output 0 alone keeps the latch check cheap
  a_latch_hold: assert property (@(posedge clock) disable iff (!nrst)
    !(slot_tick && g_out[0].local_slot == SLOT_LAST) |=> $stable(latched[0]))
    else $error("duty changed mid period");
  c_normal: cover property (@(posedge clock) disable iff (!nrst) mode == RGBP_NORMAL);
  c_soft: cover property (@(posedge clock) disable iff (!nrst) mode == RGBP_SOFT);
  c_red_on: cover property (@(posedge clock) disable iff (!nrst) colour_on[0]);
  c_sync: cover property (@(posedge clock) disable iff (!nrst) sync_on && audio_led_current != 8'h00);
  c_boost_restart: cover property (@(posedge clock) disable iff (!nrst)
    mode == RGBP_NORMAL && boost_bit && !boost_prev);
endmodule

// ==== tb/rgbp_audio_src.sv ====
`timescale 1ns/10ps
module rgbp_audio_src #(
  parameter int HALF = 20
) (
  // Clock
  input  wire logic        clock,
  // Tone setup
  input  wire logic [10:0] amp,
  input  wire logic [1:0]  chan_en,
  // Samples towards the block
  output logic      [11:0] audio_left,
  output logic      [11:0] audio_right
);
  // ---------------------------------------------------------------
  // Square tone
  // ---------------------------------------------------------------
  // Zero mean, so the high-pass keeps the full swing
  int          cnt = 0;
  logic        ph  = 1'b0;
  logic [11:0] smp;
  always @(posedge clock) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      ph <= ~ph;
    end
  end
  assign smp         = ph ? {1'b0, amp} : 12'(-{1'b0, amp});
  assign audio_left  = chan_en[0] ? smp : 12'h000;
  assign audio_right = chan_en[1] ? smp : 12'h000;
endmodule

// ==== tb/rgbp_tb_top.sv ====
`timescale 1ns/10ps
module rgbp_tb_top;
  import rgbp_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [7:0]  rdata;
  logic [10:0] amp   = 11'h000;
  logic [1:0]  chan  = 2'b00;
  logic [11:0] audio_left;
  logic [11:0] audio_right;
  logic [11:0] colour_on;
  logic [23:0] colour_cur_sel;
  logic        audio_led_enable;
  logic [7:0]  audio_led_current;
  logic [7:0]  lvl;
  int          err_total    = 0;
  int          total_checks = 0;
  int          on_c[12];
  int          rise_c[12];
  int          co;
  int          cr;
  // Set 2 green at zero, blue full; sets 3 and 4 full on
  localparam logic [7:0] CV [12] = '{8'h85, 8'h45, 8'hC5, 8'h05,
    8'h00, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
  localparam int RISES [4] = '{1, 2, 4, 4};

  initial begin
    forever #12.5 clock = ~clock;
  end

  rgbp_core #(.SOFTSTART_CYCLES(20), .REFRESH_CYCLES(64)) dut_u (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .audio_left(audio_left),
    .audio_right(audio_right), .colour_on(colour_on),
    .colour_cur_sel(colour_cur_sel),
    .audio_led_enable(audio_led_enable),
    .audio_led_current(audio_led_current));

  rgbp_audio_src src_u (.clock(clock), .amp(amp), .chan_en(chan),
    .audio_left(audio_left), .audio_right(audio_right));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Counts on-cycles and rising edges per output over n cycles
  task automatic measure(input int n);
    logic [11:0] p;
    on_c   = '{default: 0};
    rise_c = '{default: 0};
    co = 0;
    cr = 0;
    p  = colour_on;
    repeat (n) begin
      @(negedge clock);
      for (int i = 0; i < 12; i++) begin
        on_c[i]   += int'(colour_on[i]);
        rise_c[i] += int'(colour_on[i] & ~p[i]);
      end
      if (colour_on[0] & ~p[0] & p[2] & ~colour_on[2]) co++;
      if (colour_on[0] & ~p[0] & colour_on[3] & ~p[3]) cr++;
      p = colour_on;
    end
  endtask

  task automatic tone(input logic [10:0] a, input logic [1:0] c);
    @(posedge clock);
    amp  <= a;
    chan <= c;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 15; a++) begin
      rd_reg(8'(a), lvl);
      chk(lvl, REG_RESET_VAL);
    end
    rd_reg(REG_STATUS, lvl);
    chk(lvl, 8'h01);
    wr_reg(8'h20, 8'hFF);
    rd_reg(8'h20, lvl);
    chk(lvl, 8'h00);
    for (int a = 0; a < 12; a++) wr_reg(8'(a), CV[a]);
    for (int a = 0; a < 12; a++) begin
      rd_reg(8'(a), lvl);
      chk(lvl, CV[a]);
    end
  endtask

  task automatic t_standby();
    wr_reg(REG_ENABLES, 8'h0F);
    measure(4100);
    for (int i = 0; i < 12; i++) chk(on_c[i], 0);
  endtask

  task automatic t_soft();
    wr_reg(REG_ENABLES, 8'hC5);
    rd_reg(REG_STATUS, lvl);
    chk(lvl, 8'h02);
    measure(10);
    for (int i = 0; i < 12; i++) chk(on_c[i], 0);
    idle(30);
    rd_reg(REG_STATUS, lvl);
    chk(lvl, 8'h04);
  endtask

  task automatic t_pwm();
    idle(8100);
    measure(4032);
    chk(on_c[0], 5 * 64);
    chk(rise_c[0], 1);
    chk(co, 1);
    chk(on_c[6], 4032);
    chk(on_c[3] + on_c[5] + on_c[9] + on_c[11], 0);
    chk(colour_cur_sel[5:0], {CV[2][7:6], CV[1][7:6], CV[0][7:6]});
    chk(colour_cur_sel[13:12], 2'b00);
  endtask

  task automatic t_freq();
    wr_reg(REG_ENABLES, 8'h87);
    for (int c = 0; c < 4; c++) begin
      wr_reg(REG_FREQ_SEL, 8'(c << 3));
      idle(4100);
      measure(4032);
      chk(rise_c[0], RISES[c]);
      chk(on_c[0], 5 * 64);
      chk(rise_c[3], RISES[c]);
      chk(cr, 0);
    end
  endtask

  task automatic t_audio();
    wr_reg(REG_AUDIO_LED_LEVEL, 8'h80);
    idle(4200);
    chk(audio_led_enable, 1);
    chk(audio_led_current, 8'h80);
    wr_reg(REG_AUDIO_SYNC_CTRL, 8'h05);
    idle(300);
    chk(audio_led_enable, 1);
    chk(audio_led_current, 8'h00);
    tone(11'h3E8, 2'b01);
    idle(600);
    lvl = audio_led_current;
    chk(lvl != 8'h00, 1);
    tone(11'h3E8, 2'b10);
    idle(600);
    chk(audio_led_current != 8'h00, 1);
    wr_reg(REG_AUDIO_SYNC_CTRL, 8'hE5);
    idle(900);
    chk(audio_led_current < lvl, 1);
    tone(11'h064, 2'b01);
    wr_reg(REG_AUDIO_SYNC_CTRL, 8'h05);
    idle(900);
    chk(audio_led_current != 8'h00, 1);
    wr_reg(REG_AUDIO_THRESHOLD, 8'h0F);
    idle(900);
    chk(audio_led_current, 8'h00);
    wr_reg(REG_AUDIO_SYNC_CTRL, 8'h00);
    wr_reg(REG_AUDIO_LED_LEVEL, 8'h00);
    idle(4200);
    chk(audio_led_enable, 0);
  endtask

  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_standby();
    t_soft();
    t_pwm();
    t_freq();
    t_audio();
    test_done();
  end

  // Tests need about 62k cycles; leave generous margin
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    test_done();
  end
endmodule
